// ### core/phase_corr_pkg.sv
/*
 * types shared by the phase correction configuration bank.
 * assumes: nothing beyond a systemverilog compiler.
 */
package phase_corr_pkg;

    // mode control word, bit 23 down to bit 0
    typedef struct packed {
        logic        rsvd_top;
        logic        alias_manual_override;
        logic [17:0] rsvd_mid;
        logic        offset_corr_saturate_sel;
        logic        temp_corr_saturate_sel;
        logic        linearity_corr_saturate_sel;
        logic        freq_corr_saturate_sel;
    } mode_ctrl_t;

    // emitter offset word: coefficient slice above, offset below
    typedef struct packed {
        logic [7:0]  coef_slice;
        logic [15:0] phase_offset;
    } emitter_word_t;

    // corrections that arrive from the datapath
    typedef struct packed {
        logic signed [15:0] freq_delta;
        logic signed [15:0] linearity_delta;
        logic signed [15:0] temp_delta;
    } corr_delta_t;

    // de-alias steering pair
    typedef struct packed {
        logic freq_select;
        logic enable;
    } alias_ctl_t;

endpackage

// ### core/phase_corr_regs.svh
/*
 * register offsets, field positions and reset values of the phase
 * correction configuration bank.
 * assumes: included by bare name; holds definitions only.
 */
`ifndef PHASE_CORR_REGS_SVH
`define PHASE_CORR_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define PCR_ADDR_W            8
`define PCR_DATA_W            24
`define PCR_MODE_CTRL_OFS     8'h50
`define PCR_E0_HIGH_OFS       8'h51
`define PCR_E1_LOW_OFS        8'h52
`define PCR_E1_HIGH_OFS       8'h53

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PCR_RSVD_TOP_BIT      23
`define PCR_OVERRIDE_BIT      22
`define PCR_RSVD_MID_HI       21
`define PCR_RSVD_MID_LO       4
`define PCR_OFFSET_SAT_BIT    3
`define PCR_TEMP_SAT_BIT      2
`define PCR_LIN_SAT_BIT       1
`define PCR_FREQ_SAT_BIT      0
`define PCR_OFS_HI            15
`define PCR_OFS_LO            0
`define PCR_COEF_HI_HI        23
`define PCR_COEF_HI_LO        16
`define PCR_COEF_LO_HI        23
`define PCR_COEF_LO_LO        20

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PCR_MODE_CTRL_RST     24'h200100
`define PCR_RSVD_MID_VAL      18'h20010
`define PCR_COEF_REG_RST      24'h000000
`define PCR_PHASE_W           16

`endif

// ### core/phase_correction_config_regs.sv
/*
 * configuration bank of the phase correction path: mode control word,
 * per-emitter phase offsets and thermal coefficients, plus the four
 * chained correction steps that the saturate selectors steer.
 * assumes: the register port is driven by the serial control decoder
 * on ref_clk; datapath deltas and steering levels come from ref_clk
 * logic as well, so nothing here is resynchronised.
 */
`timescale 1ns/100ps
`include "phase_corr_regs.svh"

// What this block does
// - override bit hands de-alias controls to software
// - bit 3 clips or wraps offset correction
// - bit 2 clips or wraps temperature correction
// - bit 1 clips or wraps nonlinearity correction
// - bit 0 clips or wraps frequency correction
// - 51h low half: emitter zero high offset
// - 52h low half: emitter one low offset
// - thermal coefficient split over 51h and 52h
// - 53h: emitter one high offset, coefficient
module phase_correction_config_regs (
    // clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           rst,
    // register port
    input  wire logic [`PCR_ADDR_W-1:0]         reg_addr,
    input  wire logic                           reg_wr_en,
    input  wire logic [`PCR_DATA_W-1:0]         reg_wr_data,
    input  wire logic                           reg_rd_en,
    output logic [`PCR_DATA_W-1:0]              reg_rd_data,
    output logic                                reg_rd_valid,
    // de-alias steering
    input  wire phase_corr_pkg::alias_ctl_t     alias_auto,
    input  wire phase_corr_pkg::alias_ctl_t     alias_user,
    output phase_corr_pkg::alias_ctl_t          alias_resolve,
    // phase datapath
    input  wire logic                           phase_in_valid,
    input  wire logic [`PCR_PHASE_W-1:0]        phase_in,
    input  wire phase_corr_pkg::corr_delta_t    corr_delta,
    input  wire logic                           emitter_sel,
    input  wire logic                           high_current,
    output logic                                phase_out_valid,
    output logic [`PCR_PHASE_W-1:0]             phase_out,
    // coefficient outputs
    output logic [11:0]                         emitter0_high_thermal_coef,
    output logic [7:0]                          emitter1_low_thermal_coef_upper
);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    phase_corr_pkg::mode_ctrl_t    mode_r, mode_nxt;
    phase_corr_pkg::emitter_word_t e0_high_r, e0_high_nxt;
    logic [`PCR_DATA_W-1:0]        e1_low_r, e1_low_nxt;
    phase_corr_pkg::emitter_word_t e1_high_r, e1_high_nxt;
    logic [`PCR_DATA_W-1:0]        rd_data_r, rd_data_nxt;
    logic                          rd_valid_r, rd_valid_nxt;

    // all fields are plain storage; reserved bits are kept as written
    // because the host is the one obliged to hold them at their values
    always_comb begin
        mode_nxt    = mode_r;
        e0_high_nxt = e0_high_r;
        e1_low_nxt  = e1_low_r;
        e1_high_nxt = e1_high_r;
        if (reg_wr_en) begin
            case (reg_addr)
                `PCR_MODE_CTRL_OFS: begin
                    mode_nxt = reg_wr_data;
                end
                `PCR_E0_HIGH_OFS: begin
                    e0_high_nxt = reg_wr_data;
                end
                `PCR_E1_LOW_OFS: begin
                    e1_low_nxt = reg_wr_data;
                end
                `PCR_E1_HIGH_OFS: begin
                    e1_high_nxt = reg_wr_data;
                end
                default: begin
                    mode_nxt = mode_r;
                end
            endcase
        end
    end

    always_comb begin
        rd_valid_nxt = reg_rd_en;
        rd_data_nxt  = rd_data_r;
        if (reg_rd_en) begin
            case (reg_addr)
                `PCR_MODE_CTRL_OFS: begin
                    rd_data_nxt = mode_r;
                end
                `PCR_E0_HIGH_OFS: begin
                    rd_data_nxt = e0_high_r;
                end
                `PCR_E1_LOW_OFS: begin
                    rd_data_nxt = e1_low_r;
                end
                `PCR_E1_HIGH_OFS: begin
                    rd_data_nxt = e1_high_r;
                end
                default: begin
                    rd_data_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_r     <= `PCR_MODE_CTRL_RST;
            e0_high_r  <= `PCR_COEF_REG_RST;
            e1_low_r   <= `PCR_COEF_REG_RST;
            e1_high_r  <= `PCR_COEF_REG_RST;
            rd_data_r  <= '0;
            rd_valid_r <= 1'b0;
        end else begin
            mode_r     <= mode_nxt;
            e0_high_r  <= e0_high_nxt;
            e1_low_r   <= e1_low_nxt;
            e1_high_r  <= e1_high_nxt;
            rd_data_r  <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    assign reg_rd_data  = rd_data_r;
    assign reg_rd_valid = rd_valid_r;

    // ------------------------------------------------------------
    // de-alias steering and coefficients
    // ------------------------------------------------------------
    // override is a plain level: no glitch filtering, change it between frames
    assign alias_resolve = mode_r.alias_manual_override ? alias_user : alias_auto;

    assign emitter0_high_thermal_coef =
        {e0_high_r.coef_slice, e1_low_r[`PCR_COEF_LO_HI:`PCR_COEF_LO_LO]};
    assign emitter1_low_thermal_coef_upper = e1_high_r.coef_slice;

    // ------------------------------------------------------------
    // correction chain
    // ------------------------------------------------------------
    logic signed [`PCR_PHASE_W-1:0] step_delta [4];
    logic [3:0]                     step_sat;
    logic [`PCR_PHASE_W-1:0]        step_phase [5];
    logic [`PCR_PHASE_W-1:0]        offset_sel;

    // emitter zero at low current lives outside this bank: no offset
    always_comb begin
        case ({emitter_sel, high_current})
            2'b01: begin
                offset_sel = e0_high_r.phase_offset;
            end
            2'b10: begin
                offset_sel = e1_low_r[`PCR_OFS_HI:`PCR_OFS_LO];
            end
            2'b11: begin
                offset_sel = e1_high_r.phase_offset;
            end
            default: begin
                offset_sel = '0;
            end
        endcase
    end

    assign step_delta[0] = corr_delta.freq_delta;
    assign step_delta[1] = corr_delta.linearity_delta;
    assign step_delta[2] = corr_delta.temp_delta;
    assign step_delta[3] = $signed(offset_sel);
    assign step_sat[0]   = mode_r.freq_corr_saturate_sel;
    assign step_sat[1]   = mode_r.linearity_corr_saturate_sel;
    assign step_sat[2]   = mode_r.temp_corr_saturate_sel;
    assign step_sat[3]   = mode_r.offset_corr_saturate_sel;
    assign step_phase[0] = phase_in;

    // order follows the datapath: frequency, nonlinearity, temperature, offset
    generate
        for (genvar i = 0; i < 4; i++) begin : g_step
            phase_step #(.W(`PCR_PHASE_W)) u_step (
                .phase    (step_phase[i]),
                .delta    (step_delta[i]),
                .saturate (step_sat[i]),
                .result   (step_phase[i+1])
            );
        end
    endgenerate

    logic [`PCR_PHASE_W-1:0] phase_r, phase_nxt;
    logic                    pvalid_r, pvalid_nxt;

    always_comb begin
        pvalid_nxt = phase_in_valid;
        phase_nxt  = phase_in_valid ? step_phase[4] : phase_r;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_r  <= '0;
            pvalid_r <= 1'b0;
        end else begin
            phase_r  <= phase_nxt;
            pvalid_r <= pvalid_nxt;
        end
    end

    assign phase_out       = phase_r;
    assign phase_out_valid = pvalid_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    localparam logic [`PCR_PHASE_W-1:0] PMAX = '1;

    sequence s_write_mode;
        reg_wr_en && reg_addr == `PCR_MODE_CTRL_OFS;
    endsequence

    sequence s_read_mode;
        reg_rd_en && reg_addr == `PCR_MODE_CTRL_OFS && !reg_wr_en;
    endsequence

    a_override_steer: assert property (@(posedge ref_clk) disable iff (rst)
        s_write_mode ##1 mode_r.alias_manual_override |-> alias_resolve == alias_user)
        else $error("override set but de-alias pair not from software");

    a_auto_steer: assert property (@(posedge ref_clk) disable iff (rst)
        !mode_r.alias_manual_override |-> alias_resolve == alias_auto)
        else $error("override clear but de-alias pair not automatic");

    a_write_readback: assert property (@(posedge ref_clk) disable iff (rst)
        s_write_mode ##1 !reg_wr_en ##1 s_read_mode
        |=> reg_rd_valid && reg_rd_data == $past(reg_wr_data, 3))
        else $error("mode word read back differs from stored value");

    a_reset_mode: assert property (@(posedge ref_clk)
        $past(rst) |-> mode_r == `PCR_MODE_CTRL_RST && !reg_rd_valid)
        else $error("mode word not at reset value after reset");

    a_wrap_offset: assert property (@(posedge ref_clk) disable iff (rst)
        phase_in_valid && !mode_r.offset_corr_saturate_sel
        |=> phase_out == $past(step_phase[3] + offset_sel))
        else $error("offset correction did not wrap");

    a_clip_temp_high: assert property (@(posedge ref_clk) disable iff (rst)
        mode_r.temp_corr_saturate_sel && !step_delta[2][`PCR_PHASE_W-1]
        && ({1'b0, step_phase[2]} + {1'b0, step_delta[2]} > {1'b0, PMAX})
        |-> step_phase[3] == PMAX)
        else $error("temperature correction did not clip high");

    a_clip_lin_low: assert property (@(posedge ref_clk) disable iff (rst)
        mode_r.linearity_corr_saturate_sel && step_delta[1][`PCR_PHASE_W-1]
        && (step_phase[1] < -step_delta[1]) |-> step_phase[2] == '0)
        else $error("nonlinearity correction did not clip low");

    a_wrap_freq: assert property (@(posedge ref_clk) disable iff (rst)
        !mode_r.freq_corr_saturate_sel |-> step_phase[1] == phase_in + step_delta[0])
        else $error("frequency correction did not wrap");

    a_e0_offset_use: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_wr_en && reg_addr == `PCR_E0_HIGH_OFS) ##1 (!emitter_sel && high_current)
        |-> offset_sel == $past(reg_wr_data[`PCR_OFS_HI:`PCR_OFS_LO]))
        else $error("emitter zero high offset not applied");

    a_e1_low_use: assert property (@(posedge ref_clk) disable iff (rst)
        emitter_sel && !high_current |-> offset_sel == e1_low_r[15:0])
        else $error("emitter one low offset not applied");

    a_coef_join: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_wr_en && reg_addr == `PCR_E1_LOW_OFS) |=>
        emitter0_high_thermal_coef[3:0] == $past(reg_wr_data[23:20])
        && emitter0_high_thermal_coef[11:4] == e0_high_r[23:16])
        else $error("thermal coefficient halves misassembled");

    a_e1_high_fields: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_wr_en && reg_addr == `PCR_E1_HIGH_OFS) ##1 (!reg_wr_en)[*2]
        |-> emitter1_low_thermal_coef_upper == $past(reg_wr_data[23:16], 2))
        else $error("emitter one high register fields lost");

    a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (rst)
        reg_rd_en && (reg_addr < `PCR_MODE_CTRL_OFS || reg_addr > `PCR_E1_HIGH_OFS)
        |=> reg_rd_valid && reg_rd_data == '0)
        else $error("unmapped read did not return zero");

endmodule

// ### core/phase_step.sv
/*
 * one correction step: adds a signed delta to an unsigned phase and
 * either clips at the range ends or wraps modulo the range.
 * assumes: purely combinational; the caller registers the result.
 */
`timescale 1ns/100ps

module phase_step #(
    parameter int W = 16
) (
    // operands
    input  wire logic [W-1:0]        phase,
    input  wire logic signed [W-1:0] delta,
    input  wire logic                saturate,
    // result
    output logic [W-1:0]             result
);

    logic signed [W+1:0] sum;

    generate
        if (W < 2) begin : g_bad_width
            $error("phase_step width must be at least 2");
        end
    endgenerate

    always_comb begin
        sum = $signed({2'b00, phase}) + $signed({{2{delta[W-1]}}, delta});
        if (saturate && sum < 0) begin
            result = '0;
        end else if (saturate && sum > $signed({2'b00, {W{1'b1}}})) begin
            result = '1;
        end else begin
            result = sum[W-1:0];
        end
    end

endmodule

// ### verification/phase_correction_config_regs_bench.sv
/*
 * self-checking bench of the phase correction configuration bank:
 * register access, de-alias steering, coefficient outputs and the
 * clip or wrap behaviour of each correction step.
 * assumes: core/phase_corr_regs.svh on the include path, package and
 * design files compiled first; single ref_clk domain.
 */
`timescale 1ns/100ps
`include "phase_corr_regs.svh"

module phase_correction_config_regs_bench;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic                        ref_clk;
    logic                        rst;
    logic [7:0]                  reg_addr;
    logic                        reg_wr_en;
    logic [23:0]                 reg_wr_data;
    logic                        reg_rd_en;
    logic [23:0]                 reg_rd_data;
    logic                        reg_rd_valid;
    phase_corr_pkg::alias_ctl_t  alias_auto;
    phase_corr_pkg::alias_ctl_t  alias_user;
    phase_corr_pkg::alias_ctl_t  alias_resolve;
    logic                        phase_in_valid;
    logic [15:0]                 phase_in;
    phase_corr_pkg::corr_delta_t corr_delta;
    logic                        emitter_sel;
    logic                        high_current;
    logic                        phase_out_valid;
    logic [15:0]                 phase_out;
    logic [11:0]                 coef0;
    logic [7:0]                  coef1_upper;
    int                          fail_count;
    int                          compares;

    phase_correction_config_regs DUT (
        .ref_clk                         (ref_clk),
        .rst                             (rst),
        .reg_addr                        (reg_addr),
        .reg_wr_en                       (reg_wr_en),
        .reg_wr_data                     (reg_wr_data),
        .reg_rd_en                       (reg_rd_en),
        .reg_rd_data                     (reg_rd_data),
        .reg_rd_valid                    (reg_rd_valid),
        .alias_auto                      (alias_auto),
        .alias_user                      (alias_user),
        .alias_resolve                   (alias_resolve),
        .phase_in_valid                  (phase_in_valid),
        .phase_in                        (phase_in),
        .corr_delta                      (corr_delta),
        .emitter_sel                     (emitter_sel),
        .high_current                    (high_current),
        .phase_out_valid                 (phase_out_valid),
        .phase_out                       (phase_out),
        .emitter0_high_thermal_coef      (coef0),
        .emitter1_low_thermal_coef_upper (coef1_upper)
    );

    // ----------------------------------------------------------------
    // clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // run needs about 150 cycles; generous margin
    initial begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        stop_test();
    end

    // ----------------------------------------------------------------
    // tasks: wr, rd and send start and end 1 ns after a rising edge
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_wr_en = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask

    // valid is a one-cycle pulse, so it is looked at right after the edge
    task automatic rd(input logic [7:0] a, input logic [23:0] exp);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_rd_en = 1'b0;
        chk("rd_valid", 24'h1, {23'h0, reg_rd_valid});
        chk("rd_data", exp, reg_rd_data);
        @(posedge ref_clk);
        #1;
        chk("rd_valid_drop", 24'h0, {23'h0, reg_rd_valid});
    endtask

    task automatic send(input logic [15:0] ph, input logic sel, input logic hi,
                        input logic [15:0] exp);
        phase_in = ph;
        emitter_sel = sel;
        high_current = hi;
        phase_in_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        phase_in_valid = 1'b0;
        chk("out_valid", 24'h1, {23'h0, phase_out_valid});
        chk("phase_out", {8'h0, exp}, {8'h0, phase_out});
        @(posedge ref_clk);
        #1;
        chk("out_valid_drop", 24'h0, {23'h0, phase_out_valid});
    endtask

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] ph;
        logic [15:0] d;
        logic [15:0] exp;
        fail_count = 0;
        compares = 0;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 24'h000000;
        reg_rd_en = 1'b0;
        alias_auto = 2'h2;
        alias_user = 2'h1;
        phase_in_valid = 1'b0;
        phase_in = 16'h0000;
        corr_delta = '0;
        emitter_sel = 1'b0;
        high_current = 1'b0;
        repeat (16) @(posedge ref_clk);
        #1;
        rst = 1'b0;

        // reset values, unmapped places answer zero
        rd(`PCR_MODE_CTRL_OFS, 24'h200100);
        rd(`PCR_E0_HIGH_OFS, 24'h000000);
        rd(`PCR_E1_LOW_OFS, 24'h000000);
        rd(`PCR_E1_HIGH_OFS, 24'h000000);
        wr(8'h54, 24'hffffff);
        rd(8'h54, 24'h000000);
        rd(8'h4f, 24'h000000);
        $display("test reset and unmapped done");

        // de-alias steering follows the override bit
        chk("alias_auto", 24'h2, {22'h0, alias_resolve});
        wr(`PCR_MODE_CTRL_OFS, 24'h600103);
        chk("alias_user", 24'h1, {22'h0, alias_resolve});
        rd(`PCR_MODE_CTRL_OFS, 24'h600103);
        wr(`PCR_MODE_CTRL_OFS, 24'h200100);
        chk("alias_back", 24'h2, {22'h0, alias_resolve});
        $display("test alias steering done");

        // offsets and split coefficient
        wr(`PCR_E0_HIGH_OFS, 24'ha50020);
        wr(`PCR_E1_LOW_OFS, 24'hc70030);
        wr(`PCR_E1_HIGH_OFS, 24'h3c0040);
        rd(`PCR_E0_HIGH_OFS, 24'ha50020);
        rd(`PCR_E1_LOW_OFS, 24'hc70030);
        rd(`PCR_E1_HIGH_OFS, 24'h3c0040);
        chk("coef0", 24'h000a5c, {12'h0, coef0});
        chk("coef1_upper", 24'h00003c, {16'h0, coef1_upper});
        send(16'h1000, 1'b0, 1'b1, 16'h1020);
        send(16'h1000, 1'b1, 1'b0, 16'h1030);
        send(16'h1000, 1'b1, 1'b1, 16'h1040);
        send(16'h1000, 1'b0, 1'b0, 16'h1000);
        $display("test offsets done");

        // each step overflowing up and down, wrap then clip
        for (int b = 0; b < 4; b++) begin
            for (int s = 0; s < 2; s++) begin
                for (int dn = 0; dn < 2; dn++) begin
                    ph = (dn == 1) ? 16'h0010 : 16'hfff0;
                    d = (dn == 1) ? 16'hffe0 : 16'h0020;
                    if (s == 1)
                        exp = (dn == 1) ? 16'h0000 : 16'hffff;
                    else
                        exp = (dn == 1) ? 16'hfff0 : 16'h0010;
                    wr(`PCR_MODE_CTRL_OFS, 24'h200100 | (24'(s) << b));
                    wr(`PCR_E0_HIGH_OFS, {8'ha5, (b == 3) ? d : 16'h0000});
                    corr_delta = '0;
                    if (b == 0)
                        corr_delta.freq_delta = d;
                    if (b == 1)
                        corr_delta.linearity_delta = d;
                    if (b == 2)
                        corr_delta.temp_delta = d;
                    send(ph, 1'b0, 1'b1, exp);
                end
            end
        end
        corr_delta = '0;
        $display("test clip and wrap done");
        stop_test();
    end

endmodule
